// >>> aux_clk_pkg.sv
// Constants for the auxiliary clock output and synthesizer override block
// Notes on behaviour
// RQ1: Aux output driven only while enable set
// RQ2: Aux output carries lane-derived receiver clock
// RQ3: Select 0/1/2 gives 16/32/64 UI; 3 timestamp
// RQ4: Host changes select only while disabled
// RQ5: Lane modes stop during serializer re-init
// RQ6: Override bit picks registers over pins
// RQ7: Output D select: off, div1, div2, div4
// RQ8: Pin mode: config pins set C, D
// RQ9: D clocks only while C clocks
// RQ10: Output C select: off, div1, div2, div4
// RQ11: Override bit 1 selects single-ended reference
// RQ12: Override bit 0 enables synthesizer
// RQ13: Trim register read-write, top bit reserved
// RQ14: Host avoids trim access during calibration
// RQ15: Host holds synth reset while programming
// RQ16: Reserved bits read back as written
package aux_clk_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_AUX_CTRL  = 8'h57;
  localparam logic [7:0] ADDR_SYNTH_OVR = 8'h58;
  localparam logic [7:0] ADDR_OSC_TRIM  = 8'h59;
  localparam logic [7:0] RESET_AUX_CTRL  = 8'h00;
  localparam logic [7:0] RESET_SYNTH_OVR = 8'h00;
  localparam logic [7:0] RESET_OSC_TRIM  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int AUX_EN_BIT     = 7;
  localparam int AUX_SEL_HI     = 2;
  localparam int AUX_SEL_LO     = 0;
  localparam int OVR_EN_BIT     = 7;
  localparam int OVR_D_HI       = 5;
  localparam int OVR_D_LO       = 4;
  localparam int OVR_C_HI       = 3;
  localparam int OVR_C_LO       = 2;
  localparam int OVR_SE_BIT     = 1;
  localparam int OVR_SYNTH_BIT  = 0;
  localparam int TRIM_HI        = 6;
  localparam int TRIM_LO        = 0;

  // ----------------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] AUX_SEL_16UI  = 3'h0;
  localparam logic [2:0] AUX_SEL_32UI  = 3'h1;
  localparam logic [2:0] AUX_SEL_64UI  = 3'h2;
  localparam logic [2:0] AUX_SEL_TSTMP = 3'h3;
  localparam logic [1:0] REF_SEL_OFF   = 2'h0;
  localparam logic [1:0] REF_SEL_DIV1  = 2'h1;
  localparam logic [1:0] REF_SEL_DIV2  = 2'h2;
  localparam logic [1:0] REF_SEL_DIV4  = 2'h3;
  // Half periods in UI ticks for the lane-derived clocks
  localparam logic [5:0] HALF_16UI = 6'h08;
  localparam logic [5:0] HALF_32UI = 6'h10;
  localparam logic [5:0] HALF_64UI = 6'h20;
  // Half periods in reference ticks for the divided outputs
  localparam logic [1:0] HALF_DIV1 = 2'h1;
  localparam logic [1:0] HALF_DIV2 = 2'h1;
  localparam logic [1:0] HALF_DIV4 = 2'h2;

endpackage

// >>> ref_divider.sv
// Tick-driven divided reference clock output with off/div1/div2/div4 select
`timescale 1ns/100ps
module ref_divider
  import aux_clk_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       refTick,
  input  wire logic [1:0] divSel,
  // Output
  output logic            clkOut
);

  logic [1:0] tickCnt_reg;
  logic [1:0] halfLen;

  // Half period in reference ticks for the selected division
  always_comb begin
    unique case (divSel)
      REF_SEL_DIV1: halfLen = HALF_DIV1;
      REF_SEL_DIV2: halfLen = HALF_DIV2;
      REF_SEL_DIV4: halfLen = HALF_DIV4;
      default:      halfLen = HALF_DIV1;
    endcase
  end

  // Divider: div1 follows the tick, div2 toggles per tick, div4 per 2 ticks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickCnt_reg <= 2'h0;
      clkOut      <= 1'b0;
    end else if (divSel == REF_SEL_OFF) begin
      tickCnt_reg <= 2'h0;
      clkOut      <= 1'b0;
    end else if (divSel == REF_SEL_DIV1) begin
      clkOut <= refTick;
    end else if (refTick) begin
      if (tickCnt_reg + 2'h1 >= halfLen) begin
        tickCnt_reg <= 2'h0;
        clkOut      <= ~clkOut;
      end else begin
        tickCnt_reg <= tickCnt_reg + 2'h1;
      end
    end
  end

endmodule

// >>> aux_clock_out.sv
// Auxiliary clock output, synthesizer pin override and trim register
`timescale 1ns/100ps
module aux_clock_out
  import aux_clk_pkg::*;
#(
  parameter int UI_CNT_W = 6
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register port from the serial configuration front end
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic [7:0]      regRdData,
  // Serializer side
  input  wire logic       uiTick,
  input  wire logic       serInit,
  input  wire logic       timestampInput,
  // Auxiliary output
  output logic            auxClockOut,
  output logic            auxClockOutEn,
  // Synthesizer strap pins
  input  wire logic       synthEnablePin,
  input  wire logic       seRefSelectPin,
  input  wire logic       clockConfigPinA,
  input  wire logic       clockConfigPinB,
  // Synthesizer controls
  output logic            synthEnable,
  output logic            seRefSelect,
  // Divided reference outputs
  input  wire logic       refTick,
  output logic            refClkOutC,
  output logic            refClkOutD,
  // Calibration engine access to the trim field
  input  wire logic       calTrimWrite,
  input  wire logic [6:0] calTrimValue,
  output logic [6:0]      oscTrimValue
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]          auxCtrl_reg;
  logic [7:0]          synthOvr_reg;
  logic [7:0]          oscTrim_reg;
  logic [UI_CNT_W-1:0] uiCnt_reg;
  logic [UI_CNT_W-1:0] uiHalf;
  logic [1:0]          effCSel_reg;
  logic [1:0]          effDSel_reg;
  logic [1:0]          effCSel_next;
  logic [1:0]          effDSel_next;
  logic                auxEnable;
  logic [2:0]          auxSelect;
  logic                overrideOn;
  logic                laneMode;

  // Pin-mode decode of the clock configuration straps for output C
  function automatic logic [1:0] pinSelC(input logic a, input logic b);
    unique case ({b, a})
      2'h0:    pinSelC = REF_SEL_OFF;
      2'h1:    pinSelC = REF_SEL_DIV1;
      2'h2:    pinSelC = REF_SEL_DIV2;
      default: pinSelC = REF_SEL_DIV4;
    endcase
  endfunction

  // Pin-mode decode for output D: only the two upper strap codes clock it
  function automatic logic [1:0] pinSelD(input logic a, input logic b);
    unique case ({b, a})
      2'h2:    pinSelD = REF_SEL_DIV2;
      2'h3:    pinSelD = REF_SEL_DIV4;
      default: pinSelD = REF_SEL_OFF;
    endcase
  endfunction

  assign auxEnable  = auxCtrl_reg[AUX_EN_BIT];
  assign auxSelect  = auxCtrl_reg[AUX_SEL_HI:AUX_SEL_LO];
  assign overrideOn = synthOvr_reg[OVR_EN_BIT];
  assign laneMode   = (auxSelect <= AUX_SEL_64UI);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------

  // Aux control; whole byte stored so reserved bits read back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auxCtrl_reg <= RESET_AUX_CTRL;
    end else if (regWrite && regAddr == ADDR_AUX_CTRL) begin
      auxCtrl_reg <= regWrData; // RQ16
    end
  end

  // Override control; whole byte stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      synthOvr_reg <= RESET_SYNTH_OVR;
    end else if (regWrite && regAddr == ADDR_SYNTH_OVR) begin
      synthOvr_reg <= regWrData; // RQ16
    end
  end

  // Trim; the calibration engine wins over a host write in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscTrim_reg <= RESET_OSC_TRIM;
    end else if (calTrimWrite) begin
      oscTrim_reg[TRIM_HI:TRIM_LO] <= calTrimValue;
    end else if (regWrite && regAddr == ADDR_OSC_TRIM) begin
      oscTrim_reg <= regWrData; // RQ13
    end
  end

  assign oscTrimValue = oscTrim_reg[TRIM_HI:TRIM_LO];

  // Read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= READ_UNMAPPED;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_AUX_CTRL:  regRdData <= auxCtrl_reg;
        ADDR_SYNTH_OVR: regRdData <= synthOvr_reg;
        ADDR_OSC_TRIM:  regRdData <= oscTrim_reg; // RQ13
        default:        regRdData <= READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary output
  // ----------------------------------------------------------------------

  // Half period for the selected lane clock
  always_comb begin
    unique case (auxSelect)
      AUX_SEL_16UI: uiHalf = UI_CNT_W'(HALF_16UI); // RQ3
      AUX_SEL_32UI: uiHalf = UI_CNT_W'(HALF_32UI); // RQ3
      AUX_SEL_64UI: uiHalf = UI_CNT_W'(HALF_64UI); // RQ3
      default:      uiHalf = UI_CNT_W'(HALF_16UI);
    endcase
  end

  // Buffer enable follows the enable bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auxClockOutEn <= 1'b0;
    end else begin
      auxClockOutEn <= auxEnable; // RQ1
    end
  end

  // Divider and mux; held idle while disabled or during serializer re-init in lane modes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uiCnt_reg   <= '0;
      auxClockOut <= 1'b0;
    end else if (!auxEnable) begin
      uiCnt_reg   <= '0; // RQ1
      auxClockOut <= 1'b0;
    end else if (auxSelect == AUX_SEL_TSTMP) begin
      uiCnt_reg   <= '0;
      auxClockOut <= timestampInput; // RQ3
    end else if (!laneMode) begin
      uiCnt_reg   <= '0; // Reserved codes leave the output low
      auxClockOut <= 1'b0;
    end else if (serInit) begin
      uiCnt_reg   <= '0; // RQ5
      auxClockOut <= 1'b0;
    end else if (uiTick) begin
      if (uiCnt_reg + UI_CNT_W'(1) >= uiHalf) begin
        uiCnt_reg   <= '0;
        auxClockOut <= ~auxClockOut; // RQ2
      end else begin
        uiCnt_reg <= uiCnt_reg + UI_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Synthesizer override
  // ----------------------------------------------------------------------

  // Enable and reference select: register fields or strap pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      synthEnable <= 1'b0;
      seRefSelect <= 1'b0;
    end else if (overrideOn) begin
      synthEnable <= synthOvr_reg[OVR_SYNTH_BIT]; // RQ12
      seRefSelect <= synthOvr_reg[OVR_SE_BIT]; // RQ11
    end else begin
      synthEnable <= synthEnablePin; // RQ6
      seRefSelect <= seRefSelectPin; // RQ6
    end
  end

  // Effective divided-reference selects; D forced off while C is off
  always_comb begin
    if (overrideOn) begin
      effCSel_next = synthOvr_reg[OVR_C_HI:OVR_C_LO]; // RQ10
      effDSel_next = synthOvr_reg[OVR_D_HI:OVR_D_LO]; // RQ7
    end else begin
      effCSel_next = pinSelC(clockConfigPinA, clockConfigPinB); // RQ8
      effDSel_next = pinSelD(clockConfigPinA, clockConfigPinB); // RQ8
    end
    if (effCSel_next == REF_SEL_OFF) begin
      effDSel_next = REF_SEL_OFF; // RQ9
    end
  end

  // Registered selects feeding the dividers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      effCSel_reg <= REF_SEL_OFF;
      effDSel_reg <= REF_SEL_OFF;
    end else begin
      effCSel_reg <= effCSel_next;
      effDSel_reg <= effDSel_next;
    end
  end

  // Output C divider
  ref_divider u_div_c (
    .ref_clk (ref_clk),
    .rst     (rst),
    .refTick (refTick),
    .divSel  (effCSel_reg),
    .clkOut  (refClkOutC)
  );

  // Output D divider
  ref_divider u_div_d (
    .ref_clk (ref_clk),
    .rst     (rst),
    .refTick (refTick),
    .divSel  (effDSel_reg),
    .clkOut  (refClkOutD)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_ovr_write_on;
    regWrite && regAddr == ADDR_SYNTH_OVR && regWrData[OVR_EN_BIT];
  endsequence

  sequence s_lane_reinit;
    auxEnable && laneMode && serInit;
  endsequence

  a_aux_off_low: assert property (!auxEnable |=> !auxClockOut && !auxClockOutEn) // RQ1
    else $error("aux output active while disabled");

  a_aux_en_follow: assert property ($rose(auxEnable) |=> auxClockOutEn) // RQ1
    else $error("aux buffer not enabled after enable bit");

  a_aux_tstamp: assert property (auxEnable && auxSelect == AUX_SEL_TSTMP
    |=> auxClockOut == $past(timestampInput)) // RQ3
    else $error("timestamp not resampled onto aux output");

  a_ser_gap: assert property (s_lane_reinit ##1 serInit |-> !auxClockOut) // RQ5
    else $error("aux clock running during serializer re-init");

  a_pin_mode: assert property (!overrideOn ##1 !overrideOn
    |-> synthEnable == $past(synthEnablePin)) // RQ6
    else $error("synth enable not taken from pin");

  a_ovr_enable: assert property (s_ovr_write_on ##1 1'b1
    |=> synthEnable == $past(synthOvr_reg[OVR_SYNTH_BIT])) // RQ12
    else $error("synth enable not taken from register");

  a_ovr_seref: assert property (overrideOn
    |=> seRefSelect == $past(synthOvr_reg[OVR_SE_BIT])) // RQ11
    else $error("reference select not taken from register");

  a_c_select: assert property (overrideOn
    |=> effCSel_reg == $past(synthOvr_reg[OVR_C_HI:OVR_C_LO])) // RQ10
    else $error("output C select not from register");

  a_d_select: assert property (overrideOn
    && synthOvr_reg[OVR_C_HI:OVR_C_LO] != REF_SEL_OFF
    |=> effDSel_reg == $past(synthOvr_reg[OVR_D_HI:OVR_D_LO])) // RQ7
    else $error("output D select not from register");

  a_d_needs_c: assert property (refClkOutD
    |-> $past(effCSel_reg) != REF_SEL_OFF) // RQ9
    else $error("output D clocking while C is off");

  a_trim_write: assert property (regWrite && regAddr == ADDR_OSC_TRIM
    && !calTrimWrite |=> oscTrim_reg == $past(regWrData)) // RQ13
    else $error("trim write not stored");

endmodule

// >>> tick_source.sv
// Lane and reference tick source standing in for the far-side clocks
`timescale 1ns/100ps
module tick_source (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Ticks
  output logic      uiTick,
  output logic      refTick
);
  logic [1:0] phase_reg;

  // Lane tick every 2 cycles, reference tick every 3 cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
      uiTick    <= 1'b0;
      refTick   <= 1'b0;
    end else begin
      uiTick    <= ~uiTick;
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      refTick   <= (phase_reg == 2'h2);
    end
  end
endmodule

// >>> aux_clock_out_test.sv
// Self-checking bench for the aux clock output block
`timescale 1ns/100ps
module aux_clock_out_test;
  import aux_clk_pkg::*;
  logic       ref_clk, rst, regWrite, regRead, serInit, timestampInput;
  logic       synthEnablePin, seRefSelectPin, clockConfigPinA;
  logic       clockConfigPinB, calTrimWrite, uiTick, refTick;
  logic       auxClockOut, auxClockOutEn, synthEnable, seRefSelect;
  logic       refClkOutC, refClkOutD, pA, pC, pD;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic [6:0] calTrimValue, oscTrimValue;
  int         nErrors = 0, checksDone = 0, nA = 0, nC = 0, nD = 0;
  int         gA, gC, gD;

  // --------------------------------------------------------------
  // Clock, design and tick source
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  aux_clock_out u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .uiTick(uiTick), .serInit(serInit),
    .timestampInput(timestampInput), .auxClockOut(auxClockOut),
    .auxClockOutEn(auxClockOutEn), .synthEnablePin(synthEnablePin),
    .seRefSelectPin(seRefSelectPin), .clockConfigPinA(clockConfigPinA),
    .clockConfigPinB(clockConfigPinB), .synthEnable(synthEnable),
    .seRefSelect(seRefSelect), .refTick(refTick),
    .refClkOutC(refClkOutC), .refClkOutD(refClkOutD),
    .calTrimWrite(calTrimWrite), .calTrimValue(calTrimValue),
    .oscTrimValue(oscTrimValue));

  tick_source u_ticks (.ref_clk(ref_clk), .rst(rst), .uiTick(uiTick),
    .refTick(refTick));

  // Rising edge counters on the three clock outputs
  always @(posedge ref_clk) begin
    pA <= auxClockOut;
    pC <= refClkOutC;
    pD <= refClkOutD;
    if (auxClockOut === 1'b1 && pA === 1'b0) nA <= nA + 1;
    if (refClkOutC === 1'b1 && pC === 1'b0) nC <= nC + 1;
    if (refClkOutD === 1'b1 && pD === 1'b0) nD <= nD + 1;
  end

  // --------------------------------------------------------------
  // Access, compare and measurement tasks
  // --------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wt(1);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    wt(1);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    wt(1);
    regAddr = a;
    regRead = 1'b1;
    wt(1);
    regRead = 1'b0;
    rdVal = regRdData;
  endtask

  task automatic bad(input string m);
    nErrors++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic cmp8(input logic [7:0] got, exp, input string m);
    checksDone++;
    if (got !== exp) bad(m);
  endtask

  task automatic cmp1(input logic got, exp, input string m);
    checksDone++;
    if (got !== exp) bad(m);
  endtask

  // Edge counts may be one off depending on the window phase
  task automatic cmpN(input int got, exp, input string m);
    checksDone++;
    if (got < exp - 1 || got > exp + 1) bad(m);
  endtask

  // 768 cycles hold 384 lane ticks and 256 reference ticks
  task automatic meas;
    int a0, c0, d0;
    wt(4);
    a0 = nA;
    c0 = nC;
    d0 = nD;
    wt(768);
    gA = nA - a0;
    gC = nC - c0;
    gD = nD - d0;
  endtask

  function automatic int refRate(input logic [1:0] s);
    return (s == 2'h0) ? 0 : 256 >> (s - 2'h1);
  endfunction

  function automatic int auxRate(input logic [2:0] s);
    return (s > 3'h2) ? 0 : 24 >> s;
  endfunction

  task automatic chkRef(input logic [1:0] c, d);
    meas;
    cmpN(gC, refRate(c), "out C rate");
    cmpN(gD, (c == 2'h0) ? 0 : refRate(d), "out D rate");
  endtask

  task automatic reportAndStop;
    if (nErrors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 21k cycles
  initial begin
    #2000000;
    nErrors++;
    reportAndStop;
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {regWrite, regRead, serInit, timestampInput} = 4'h0;
    {synthEnablePin, seRefSelectPin, clockConfigPinA} = 3'h0;
    {clockConfigPinB, calTrimWrite} = 2'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    calTrimValue = 7'h00;
    rst = 1'b1;
    wt(4);
    rst = 1'b0;
    // Reset values, unmapped access, reserved bits
    rd(8'h57); cmp8(rdVal, 8'h00, "ctrl reset");
    rd(8'h58); cmp8(rdVal, 8'h00, "ovr reset");
    wr(8'h5A, 8'hFF);
    rd(8'h5A); cmp8(rdVal, 8'h00, "unmapped");
    wr(8'h57, 8'h78);
    rd(8'h57); cmp8(rdVal, 8'h78, "ctrl reserved");
    meas; cmpN(gA, 0, "aux off");
    cmp1(auxClockOutEn, 1'b0, "aux en off");
    // Select codes 0 to 4, changed only while disabled
    for (int s = 0; s < 5; s++) begin
      wr(8'h57, {5'h00, 3'(s)});
      wr(8'h57, {5'h10, 3'(s)});
      wt(2);
      cmp1(auxClockOutEn, 1'b1, "aux en on");
      if (s == 3) begin
        timestampInput = 1'b1;
        wt(2); cmp1(auxClockOut, 1'b1, "stamp hi");
        timestampInput = 1'b0;
        wt(2); cmp1(auxClockOut, 1'b0, "stamp lo");
      end else begin
        meas; cmpN(gA, auxRate(3'(s)), "aux rate");
      end
      wr(8'h57, {5'h00, 3'(s)});
    end
    // Serializer re-init stops the lane-derived clock
    wr(8'h57, 8'h00);
    wr(8'h57, 8'h80);
    serInit = 1'b1;
    meas; cmpN(gA, 0, "reinit");
    cmp1(auxClockOut, 1'b0, "reinit lvl");
    serInit = 1'b0;
    meas; cmpN(gA, 24, "resume");
    wr(8'h57, 8'h00);
    wt(2); cmp1(auxClockOutEn, 1'b0, "aux dis");
    // Synthesizer pins, then register values against opposite pins
    for (int i = 0; i < 4; i++) begin
      {synthEnablePin, seRefSelectPin} = 2'(i);
      wt(2);
      cmp1(synthEnable, i[1], "pin en");
      cmp1(seRefSelect, i[0], "pin se");
    end
    // Write to unmapped address 8'h5C, then override settings against opposite pins
    wr(8'h5C, 8'h01);
    for (int i = 0; i < 4; i++) begin
      {seRefSelectPin, synthEnablePin} = ~2'(i);
      wr(8'h58, {6'h20, 2'(i)});
      wt(2);
      cmp1(synthEnable, i[0], "ovr en");
      cmp1(seRefSelect, i[1], "ovr se");
    end
    // Register selects for every pair of C and D modes
    {clockConfigPinB, clockConfigPinA} = 2'h1;
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 4; d++) begin
        wr(8'h58, {2'h2, 2'(d), 2'(c), 2'h0});
        chkRef(2'(c), 2'(d));
      end
    end
    // Pin mode ignores the register selects
    wr(8'h58, 8'h7C);
    rd(8'h58); cmp8(rdVal, 8'h7C, "ovr reserved");
    for (int i = 0; i < 4; i++) begin
      {clockConfigPinB, clockConfigPinA} = 2'(i);
      chkRef(2'(i), (i < 2) ? 2'h0 : 2'(i));
    end
    wr(8'h5C, 8'h00);
    // Trim register, host and calibration writes
    wr(8'h59, 8'hFF);
    rd(8'h59); cmp8(rdVal, 8'hFF, "trim rw");
    cmp8({1'b0, oscTrimValue}, 8'h7F, "trim out");
    wt(1);
    calTrimValue = 7'h2A;
    calTrimWrite = 1'b1;
    wt(1);
    calTrimWrite = 1'b0;
    cmp8({1'b0, oscTrimValue}, 8'h2A, "cal out");
    rd(8'h59); cmp8(rdVal, 8'hAA, "cal read");
    reportAndStop;
  end
endmodule
